//--- rtl/dxb_core_pins.sv
// Core pin block: external register bus, halt, interrupts, reset sequence and user pins.
//
// Overview of operation
// RULE1: Address lines latched on every register access.
// RULE2: Registers 0-3 user, 4-6 shared, 7 reserved.
// RULE3: Data lines driven only for external writes.
// RULE4: Strobe asserted for external transfers only.
// RULE5: Write data valid while direction and strobe low.
// RULE6: Wait input sampled on rising clock edge.
// RULE7: Wait register bit adds one internal wait.
// RULE8: Outside party holds wait for extra states.
// RULE9: Halt high runs no-ops and holds counter.
// RULE10: Interrupts raised on rising input edges only.
// RULE11: Interrupt vectors fetched from fixed top locations.
// RULE12: Interrupt zero served first, two last.
// RULE13: Reset pushes counter then fetches reset vector.
// RULE14: Status register cleared to zero on reset.
// RULE15: Counter and stack keep contents across reset.
// RULE16: Async reset; fixed cycle count to execution.
// RULE17: User inputs testable and readable, synchronised.
// RULE18: User outputs are inverted status bits.
// RULE19: Peripheral drives data on read while strobed.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module dxb_core_pins
#(
  parameter bit WideAddr = 1'b0
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] accAddr,
  input wire logic [15:0] accWdata,
  input wire logic accWr,
  input wire logic accRd,
  output logic [15:0] accRdata,
  output logic accRdValid,
  output logic accBusy,
  input wire logic [2:0] periphDisable,
  output logic [2:0] extRegAddr,
  output logic [15:0] extRegDataOut,
  input wire logic [15:0] extRegDataIn,
  output logic extRegDataOeN,
  output logic busStrobeN,
  output logic rdWrSel,
  input wire logic extWait,
  input wire logic haltIn,
  input wire logic irqLineZero,
  input wire logic irqLineOne,
  input wire logic irqLineTwo,
  output logic [15:0] progAddr,
  output logic progRd,
  input wire logic [15:0] progData,
  output logic [15:0] programCounter,
  output logic execOp,
  input wire logic gpInputZero,
  input wire logic gpInputOne,
  output logic [1:0] condInputs,
  output logic gpOutputZero,
  output logic gpOutputOne
);

  typedef enum logic [1:0] {SEQ_PUSH, SEQ_FETCH, SEQ_LOAD, SEQ_RUN} dxb_seq_t;
  typedef enum logic {BUS_IDLE, BUS_ACCESS} dxb_bus_t;

  dxb_seq_t seqState;
  dxb_bus_t busState;
  logic [15:0] statusReg;
  logic [7:0] waitCfg;
  logic waitExtra;
  logic accIsWrite;
  logic [1:0] gpSync1;
  localparam int STACK_DEPTH_L = dxb_pkg::STACK_DEPTH;
  logic [15:0] stack [STACK_DEPTH_L];
  logic [1:0] stackPtr;
  logic accReq;
  logic accExternal;
  logic busDone;
  logic [15:0] intRdata;

  dxb_irq_if irqBus();

  // Registers 4 to 6 move outside only when their peripheral is switched off; 7 never does.
  function automatic logic isInternal(input logic [2:0] addr, input logic [2:0] disable_);
    logic [2:0] slot;
    slot = 3'(addr - dxb_pkg::REG_SHARED_FIRST);
    if (addr == dxb_pkg::REG_STATUS)
      isInternal = 1'b1; // RULE2
    else if (addr >= dxb_pkg::REG_SHARED_FIRST)
      isInternal = !disable_[slot[1:0]]; // RULE2
    else
      isInternal = 1'b0;
  endfunction

  dxb_irq_ctrl #(.WideAddr(WideAddr)) irqCtrl
  (
    .clk(clk),
    .arst_n(arst_n),
    .irqLines({irqLineTwo, irqLineOne, irqLineZero}),
    .irq(irqBus)
  );

  // Requests arriving while an external access is open are dropped; the master watches busy.
  assign accReq = (accWr || accRd) && (busState == BUS_IDLE);
  assign accExternal = !isInternal(accAddr, periphDisable);
  assign busDone = (busState == BUS_ACCESS) && !waitExtra && !extWait; // RULE6

  // Read value of the internal registers; unused shared slots read as zero.
  always_comb
  begin
    intRdata = dxb_pkg::DATA_ZERO;
    if (accAddr == dxb_pkg::REG_STATUS)
      intRdata = statusReg;
    else if (accAddr == dxb_pkg::REG_WAIT_CFG)
      intRdata = {8'h00, waitCfg};
  end

  // The address lines follow every access, internal ones too, and hold until the next.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      extRegAddr <= 3'h0;
    else if (accReq)
      extRegAddr <= accAddr; // RULE1
  end

  // External transfer sequencer: strobe, direction, data drive and wait stretching.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      busState <= BUS_IDLE;
      busStrobeN <= 1'b1;
      rdWrSel <= 1'b1;
      extRegDataOeN <= 1'b1;
      extRegDataOut <= dxb_pkg::DATA_ZERO;
      waitExtra <= 1'b0;
      accIsWrite <= 1'b0;
      accBusy <= 1'b0;
    end
    else
    begin
      unique case (busState)
        BUS_IDLE:
        begin
          if (accReq && accExternal)
          begin
            busState <= BUS_ACCESS;
            busStrobeN <= 1'b0; // RULE4
            rdWrSel <= !accWr; // RULE5
            extRegDataOeN <= !accWr; // RULE3
            extRegDataOut <= accWdata;
            waitExtra <= waitCfg[accAddr]; // RULE7
            accIsWrite <= accWr;
            accBusy <= 1'b1;
          end
        end
        BUS_ACCESS:
        begin
          if (waitExtra)
            waitExtra <= 1'b0; // RULE7
          else if (busDone)
          begin
            // Release the lines first so no drive overlaps a following read.
            busState <= BUS_IDLE;
            busStrobeN <= 1'b1;
            rdWrSel <= 1'b1;
            extRegDataOeN <= 1'b1; // RULE3
            accBusy <= 1'b0;
          end
        end
      endcase
    end
  end

  // Read answers: internal one cycle after the request, external at the closing edge.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      accRdata <= dxb_pkg::DATA_ZERO;
      accRdValid <= 1'b0;
    end
    else
    begin
      accRdValid <= 1'b0;
      if (accReq && accRd && !accExternal)
      begin
        accRdata <= intRdata;
        accRdValid <= 1'b1;
      end
      else if (busDone && !accIsWrite)
      begin
        accRdata <= extRegDataIn; // RULE19
        accRdValid <= 1'b1;
      end
    end
  end

  // Status register; cleared by reset, user outputs show its bits inverted.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      statusReg <= dxb_pkg::STATUS_RESET; // RULE14
      gpOutputZero <= 1'b1; // RULE18
      gpOutputOne <= 1'b1;
    end
    else
    begin
      if (accReq && accWr && accAddr == dxb_pkg::REG_STATUS)
      begin
        statusReg <= (accWdata & ~dxb_pkg::STATUS_RO_MASK)
          | (statusReg & dxb_pkg::STATUS_RO_MASK);
        gpOutputZero <= !accWdata[dxb_pkg::ST_GPO0_BIT]; // RULE18
        gpOutputOne <= !accWdata[dxb_pkg::ST_GPO1_BIT]; // RULE18
      end
      statusReg[dxb_pkg::ST_GPI0_BIT] <= condInputs[0]; // RULE17
      statusReg[dxb_pkg::ST_GPI1_BIT] <= condInputs[1]; // RULE17
    end
  end

  // Wait configuration, one bit for each register number.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      waitCfg <= 8'h00;
    else if (accReq && accWr && accAddr == dxb_pkg::REG_WAIT_CFG && !accExternal)
      waitCfg <= accWdata[7:0]; // RULE7
  end

  // The user inputs may change at any time, so they pass two flip-flops first.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gpSync1 <= 2'h0;
      condInputs <= 2'h0;
    end
    else
    begin
      gpSync1 <= {gpInputOne, gpInputZero};
      condInputs <= gpSync1; // RULE17
    end
  end

  // Program sequencer control: reset push, vector fetch, run, halt and interrupt entry.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seqState <= SEQ_PUSH; // RULE16
      progAddr <= dxb_pkg::DATA_ZERO;
      progRd <= 1'b0;
      execOp <= 1'b0;
    end
    else
    begin
      unique case (seqState)
        SEQ_PUSH:
        begin
          // Fixed path after release: push, fetch, load, then run.
          progAddr <= WideAddr ? dxb_pkg::VEC_RESET_WIDE : dxb_pkg::VEC_RESET_NARROW; // RULE13
          progRd <= 1'b1;
          seqState <= SEQ_FETCH; // RULE16
        end
        SEQ_FETCH:
        begin
          progRd <= 1'b0;
          seqState <= SEQ_LOAD;
        end
        SEQ_LOAD:
        begin
          seqState <= SEQ_RUN;
        end
        SEQ_RUN:
        begin
          if (haltIn)
            execOp <= 1'b0; // RULE9
          else if (irqBus.reqValid)
          begin
            execOp <= 1'b0;
            progAddr <= irqBus.reqVector; // RULE11
            progRd <= 1'b1;
            seqState <= SEQ_FETCH;
          end
          else
            execOp <= 1'b1;
        end
      endcase
    end
  end

  assign irqBus.ack = (seqState == SEQ_RUN) && !haltIn && irqBus.reqValid; // RULE12

  // Counter and stack have no reset; the counter survives a reset pulse, but stack entry 0 takes the counter on every clock while reset holds SEQ_PUSH.
  always_ff @(posedge clk) // RULE15
  begin
    if (seqState == SEQ_PUSH || irqBus.ack)
      stack[stackPtr] <= programCounter; // RULE13
    if (seqState == SEQ_LOAD)
      programCounter <= progData; // RULE13
    else if (seqState == SEQ_RUN && !haltIn && !irqBus.reqValid)
      programCounter <= programCounter + dxb_pkg::PC_STEP; // RULE9
  end

  // The stack pointer wraps; a deeper nesting overwrites the oldest entry.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      stackPtr <= 2'h0;
    else if (seqState == SEQ_PUSH || irqBus.ack)
      stackPtr <= stackPtr + 2'h1; // RULE13
  end

endmodule

//--- rtl/dxb_pkg.sv
// Shared constants for the core pin block: register map, status fields and vectors.
package dxb_pkg;

  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam int PADDR_W = 16;
  localparam int STACK_DEPTH = 4;
  localparam int STACK_PTR_W = 2;
  localparam int NUM_IRQ = 3;

  // Register numbers on the latched address lines.
  localparam logic [2:0] REG_SHARED_FIRST = 3'h4;
  localparam logic [2:0] REG_WAIT_CFG = 3'h5;
  localparam logic [2:0] REG_STATUS = 3'h7;

  // Status register fields.
  localparam int ST_GPO0_BIT = 0;
  localparam int ST_GPO1_BIT = 1;
  localparam int ST_GPI0_BIT = 2;
  localparam int ST_GPI1_BIT = 3;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RO_MASK = 16'h000C;

  // Reset and interrupt vector locations, narrow and wide address variants.
  localparam logic [15:0] VEC_RESET_NARROW = 16'h0FFC;
  localparam logic [15:0] VEC_RESET_WIDE = 16'hFFFC;
  localparam logic [15:0] VEC_IRQ0_NARROW = 16'h0FFF;
  localparam logic [15:0] VEC_IRQ1_NARROW = 16'h0FFE;
  localparam logic [15:0] VEC_IRQ2_NARROW = 16'h0FFD;
  localparam logic [15:0] VEC_IRQ0_WIDE = 16'hFFFF;
  localparam logic [15:0] VEC_IRQ1_WIDE = 16'hFFFE;
  localparam logic [15:0] VEC_IRQ2_WIDE = 16'hFFFD;

  localparam logic [15:0] PC_STEP = 16'h0001;
  localparam logic [15:0] DATA_ZERO = 16'h0000;

endpackage

//--- rtl/dxb_irq_if.sv
// Interface carrying the prioritised interrupt request between sequencer and edge logic.
`timescale 1ns/1ps
interface dxb_irq_if;
  logic reqValid;
  logic [15:0] reqVector;
  logic ack;

  modport ctrl
  (
    output reqValid,
    output reqVector,
    input ack
  );

  modport core
  (
    input reqValid,
    input reqVector,
    output ack
  );
endinterface

//--- rtl/dxb_irq_ctrl.sv
// Edge-triggered interrupt capture with fixed priority and vector selection.
`timescale 1ns/1ps
module dxb_irq_ctrl
#(
  parameter bit WideAddr = 1'b0
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] irqLines,
  dxb_irq_if.ctrl irq
);

  logic [2:0] irqPrev;
  logic armed;
  logic [2:0] pending;
  logic [2:0] risen;
  logic [2:0] ackMask;

  // Only a low-to-high change counts; a line held high raises one request.
  // The first edge after reset only loads the history, so a line already high is no edge.
  assign risen = irqLines & ~irqPrev & {3{armed}}; // RULE10

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irqPrev <= 3'h0;
      armed <= 1'b0;
    end
    else
    begin
      irqPrev <= irqLines;
      armed <= 1'b1;
    end
  end

  // Acknowledge removes the served request; a fresh edge in the same cycle survives.
  always_comb
  begin
    ackMask = 3'h0;
    if (irq.ack)
    begin
      if (pending[0])
        ackMask = 3'h1; // RULE12
      else if (pending[1])
        ackMask = 3'h2;
      else
        ackMask = 3'h4;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pending <= 3'h0;
    else
      pending <= (pending & ~ackMask) | risen; // RULE10
  end

  // Line zero wins over one, one over two.
  assign irq.reqValid = |pending;
  always_comb
  begin
    if (pending[0])
      irq.reqVector = WideAddr ? dxb_pkg::VEC_IRQ0_WIDE : dxb_pkg::VEC_IRQ0_NARROW; // RULE11
    else if (pending[1])
      irq.reqVector = WideAddr ? dxb_pkg::VEC_IRQ1_WIDE : dxb_pkg::VEC_IRQ1_NARROW; // RULE12
    else
      irq.reqVector = WideAddr ? dxb_pkg::VEC_IRQ2_WIDE : dxb_pkg::VEC_IRQ2_NARROW;
  end

endmodule

//--- sim/dxb_core_pins_props.sv
// Port assertions for the core pin block.
`timescale 1ns/1ps
module dxb_core_pins_props
#(
  parameter bit WideAddr = 1'b0
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [2:0] extRegAddr,
  input wire logic extRegDataOeN,
  input wire logic busStrobeN,
  input wire logic rdWrSel,
  input wire logic extWait,
  input wire logic haltIn,
  input wire logic [15:0] progAddr,
  input wire logic progRd,
  input wire logic execOp,
  input wire logic gpInputZero,
  input wire logic gpInputOne,
  input wire logic [1:0] condInputs
);
  // The reset fetch address follows the address width variant.
  localparam logic [15:0] RstVec =
    WideAddr ? dxb_pkg::VEC_RESET_WIDE : dxb_pkg::VEC_RESET_NARROW;

  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Bus pin relations; a stray data driver would fight the peripheral.
  strobe_ext_only_a: assert property
    (!busStrobeN |-> extRegAddr != dxb_pkg::REG_STATUS) else $error("Strobe on status.");
  drive_on_write_a: assert property
    (!extRegDataOeN |-> !busStrobeN && !rdWrSel) else $error("Data driven off a write.");
  write_data_valid_a: assert property
    (!busStrobeN && !rdWrSel |-> !extRegDataOeN) else $error("Write data not driven.");
  addr_held_a: assert property
    (!busStrobeN && $past(!busStrobeN) |-> $stable(extRegAddr)) else $error("Address moved.");
  wait_extends_a: assert property
    (!busStrobeN && extWait |=> !busStrobeN) else $error("Wait ignored.");
  halt_no_op_a: assert property
    (haltIn |=> !execOp) else $error("Step while halted.");
  reset_fetch_a: assert property
    (!$past(arst_n) |=> progRd && progAddr == RstVec) else $error("Bad reset fetch.");
  inputs_synced_a: assert property
    ($past(arst_n) && $past(arst_n, 2) |-> condInputs[0] == $past(gpInputZero, 2)
      && condInputs[1] == $past(gpInputOne, 2)) else $error("User input lag wrong.");
endmodule

bind dxb_core_pins dxb_core_pins_props #(.WideAddr(WideAddr)) dxb_core_pins_props_i (.clk,
  .arst_n, .extRegAddr, .extRegDataOeN, .busStrobeN, .rdWrSel, .extWait, .haltIn,
  .progAddr, .progRd, .execOp, .gpInputZero, .gpInputOne, .condInputs);

//--- sim/dxb_periph_model.sv
// Behavioural external peripheral: register file, read driver and wait logic.
`timescale 1ns/1ps
module dxb_periph_model
(
  input wire logic clk,
  input wire logic [2:0] extRegAddr,
  input wire logic [15:0] extRegDataOut,
  input wire logic extRegDataOeN,
  input wire logic busStrobeN,
  input wire logic rdWrSel,
  input wire logic [1:0] stallCycles,
  output logic [15:0] extRegDataIn,
  output logic extWait
);
  logic [15:0] regs [8];
  logic [15:0] lastData = 16'h0000;
  logic [1:0] waitCnt = 2'h0;

  // Wait is held for the first stallCycles edges of each strobe.
  assign extWait = !busStrobeN && waitCnt < stallCycles;
  // A released bus shows the inverse of the last driven value, so stale data cannot pass.
  assign extRegDataIn = (!busStrobeN && rdWrSel) ? regs[extRegAddr] : ~lastData;

  // Write capture, wait counting and the released-bus pattern.
  always_ff @(posedge clk)
  begin
    if (!busStrobeN && rdWrSel)
      lastData <= extRegDataIn;
    waitCnt <= busStrobeN ? 2'h0 : waitCnt + (extWait ? 2'h1 : 2'h0);
    if (!busStrobeN && !rdWrSel && !extRegDataOeN)
    begin
      regs[extRegAddr] <= extRegDataOut;
    end
  end
endmodule

//--- sim/dxb_core_pins_test.sv
// Self-checking bench for the core pin block.
`timescale 1ns/1ps
module dxb_core_pins_test;
  localparam logic [15:0] WaitCfg = 16'h000A;
  logic clk = 1'b0, arst_n = 1'b0, accWr = 1'b0, accRd = 1'b0, haltIn = 1'b0;
  logic irqLineZero = 1'b0, irqLineOne = 1'b0, irqLineTwo = 1'b0;
  logic gpInputZero = 1'b0, gpInputOne = 1'b0;
  logic [2:0] accAddr = 3'h0, periphDisable = 3'h0;
  logic [15:0] accWdata = 16'h0000, progData = 16'h0000;
  logic [1:0] stallCycles = 2'h0;
  logic [15:0] accRdata, extRegDataOut, extRegDataIn, progAddr, programCounter, progAddrWide;
  logic accRdValid, accBusy, extRegDataOeN, busStrobeN, rdWrSel, extWait, progRd, execOp;
  logic gpOutputZero, gpOutputOne;
  logic [2:0] extRegAddr;
  logic [1:0] condInputs;
  logic [15:0] fetchQ [$];
  integer seed = 32'h484f;
  int failCount = 0;
  int nCompared = 0;

  dxb_core_pins dxb_core_pins_i (.clk, .arst_n, .accAddr, .accWdata, .accWr, .accRd,
    .accRdata, .accRdValid, .accBusy, .periphDisable, .extRegAddr, .extRegDataOut,
    .extRegDataIn, .extRegDataOeN, .busStrobeN, .rdWrSel, .extWait, .haltIn, .irqLineZero,
    .irqLineOne, .irqLineTwo, .progAddr, .progRd, .progData, .programCounter, .execOp,
    .gpInputZero, .gpInputOne, .condInputs, .gpOutputZero, .gpOutputOne);
  dxb_periph_model dxb_periph_model_i (.clk, .extRegAddr, .extRegDataOut, .extRegDataOeN,
    .busStrobeN, .rdWrSel, .stallCycles, .extRegDataIn, .extWait);
  // Wide-vector variant runs in lockstep on the same inputs; only its fetch address is watched.
  dxb_core_pins #(.WideAddr(1'b1)) dxb_core_pins_wide_i (.clk, .arst_n, .accAddr, .accWdata,
    .accWr, .accRd, .accRdata(), .accRdValid(), .accBusy(), .periphDisable, .extRegAddr(),
    .extRegDataOut(), .extRegDataIn, .extRegDataOeN(), .busStrobeN(), .rdWrSel(), .extWait,
    .haltIn, .irqLineZero, .irqLineOne, .irqLineTwo, .progAddr(progAddrWide), .progRd(),
    .progData, .programCounter(), .execOp(), .gpInputZero, .gpInputOne, .condInputs(),
    .gpOutputZero(), .gpOutputOne());

  // Free-running clock.
  initial forever #2 clk = ~clk;

  // Program memory answers each fetch with the inverted address and logs it.
  always @(posedge clk)
  begin
    if (progRd)
    begin
      progData <= ~progAddr;
      fetchQ.push_back(progAddr);
    end
  end

  function automatic logic [15:0] expCyc(input logic [1:0] r, input logic [1:0] st);
    return 16'h0002 + 16'(WaitCfg[r]) + 16'(st);
  endfunction

  task automatic chk(input string what, input logic [15:0] expv, input logic [15:0] got);
    nCompared++;
    if (got !== expv)
    begin
      failCount++;
      $display("[FAIL] %s expected %h seen %h", what, expv, got);
    end
  endtask

  task automatic giveVerdict();
    $display("Compared %0d, failed %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // One access; the wait for busy or read-valid is bounded so a hang cannot stall the run.
  task automatic acc(input logic wr, input logic [2:0] a, input logic [15:0] d,
    output logic [15:0] q, output int n);
    n = 1;
    @(posedge clk);
    accWr <= wr;
    accRd <= !wr;
    accAddr <= a;
    accWdata <= d;
    @(posedge clk);
    accWr <= 1'b0;
    accRd <= 1'b0;
    #1;
    while ((accBusy !== 1'b0 || (!wr && accRdValid !== 1'b1)) && n < 40)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    q = accRdata;
    if (n == 40)
    begin
      failCount++;
      giveVerdict();
    end
  endtask

  task automatic doReset(input bit midRun);
    logic [15:0] pcHeld;
    @(posedge clk);
    arst_n <= 1'b0;
    #1;
    pcHeld = programCounter;
    repeat (4) @(posedge clk);
    if (midRun)
      chk("pc kept", pcHeld, programCounter);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("pc", ~dxb_pkg::VEC_RESET_NARROW, programCounter);
    chk("outs", 16'h0003, {14'h0000, gpOutputOne, gpOutputZero});
    chk("wide rst", dxb_pkg::VEC_RESET_WIDE, progAddrWide);
  endtask

  initial
  begin
    logic [15:0] q, w;
    int n;
    doReset(1'b0);
    acc(1'b0, dxb_pkg::REG_STATUS, 16'h0000, q, n);
    chk("status", dxb_pkg::STATUS_RESET, q);
    // Status writes show inverted on the user outputs; input bits stay read-only.
    repeat (4)
    begin
      w = $random(seed);
      acc(1'b1, dxb_pkg::REG_STATUS, w, q, n);
      acc(1'b0, dxb_pkg::REG_STATUS, 16'h0000, q, n);
      chk("status", w & ~dxb_pkg::STATUS_RO_MASK, q);
      chk("outs", {14'h0000, ~w[1:0]}, {14'h0000, gpOutputOne, gpOutputZero});
    end
    // Every user input pattern reaches the branch conditions and the status register.
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      {gpInputOne, gpInputZero} <= 2'(i);
      repeat (3) @(posedge clk);
      acc(1'b0, dxb_pkg::REG_STATUS, 16'h0000, q, n);
      chk("cond", 16'(i), {14'h0000, condInputs});
      chk("st in", 16'(i), {14'h0000, q[3:2]});
    end
    // User registers: internal waits on 1 and 3, peripheral stalls on 0 and 2.
    acc(1'b1, dxb_pkg::REG_WAIT_CFG, WaitCfg, q, n);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      stallCycles <= (i > 3 && !i[0]) ? 2'($random(seed)) | 2'h1 : 2'h0;
      w = $random(seed);
      acc(1'b1, 3'(i[1:0]), w, q, n);
      acc(1'b0, 3'(i[1:0]), 16'h0000, q, n);
      chk("data", w, q);
      chk("cycles", expCyc(i[1:0], stallCycles), 16'(n));
    end
    // Slot 4 stays internal until its peripheral is disabled.
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      periphDisable <= 3'(i);
      acc(1'b1, dxb_pkg::REG_SHARED_FIRST, 16'hC3C3, q, n);
      acc(1'b0, dxb_pkg::REG_SHARED_FIRST, 16'h0000, q, n);
      chk("slot4", (i == 1) ? 16'hC3C3 : 16'h0000, q);
      chk("slot4 cyc", 16'(i + 1), 16'(n));
    end
    // Three lines rise together and stay high: one fetch each, in priority order.
    fetchQ.delete();
    @(posedge clk);
    irqLineZero <= 1'b1;
    irqLineOne <= 1'b1;
    irqLineTwo <= 1'b1;
    repeat (40) @(posedge clk);
    chk("fetches", 16'h0003, 16'(fetchQ.size()));
    for (int k = 0; k < 3; k++)
      chk("vector", dxb_pkg::VEC_IRQ0_NARROW - 16'(k), fetchQ[k]);
    chk("wide vec", dxb_pkg::VEC_IRQ2_WIDE, progAddrWide);
    // Halt freezes the counter; an edge seen meanwhile is served after release.
    @(posedge clk);
    irqLineOne <= 1'b0;
    haltIn <= 1'b1;
    repeat (3) @(posedge clk);
    irqLineOne <= 1'b1;
    #1;
    w = programCounter;
    fetchQ.delete();
    repeat (6) @(posedge clk);
    #1;
    chk("halt pc", w, programCounter);
    chk("halt op", 16'h0000, 16'(execOp));
    chk("halt fetch", 16'h0000, 16'(fetchQ.size()));
    @(posedge clk);
    haltIn <= 1'b0;
    repeat (8) @(posedge clk);
    chk("late cnt", 16'h0001, 16'(fetchQ.size()));
    chk("late irq", dxb_pkg::VEC_IRQ1_NARROW, fetchQ[0]);
    // A second reset mid-run clears status, keeps the counter while held, reloads the vector.
    {gpInputOne, gpInputZero} <= 2'h0;
    doReset(1'b1);
    acc(1'b0, dxb_pkg::REG_STATUS, 16'h0000, q, n);
    chk("status", dxb_pkg::STATUS_RESET, q);
    giveVerdict();
  end
endmodule
